// File: hw/smbus_map.vh
// Register map, field positions and timing constants of the two-wire bus block
`ifndef SMBUS_MAP_VH
`define SMBUS_MAP_VH

// ****************************************
// Register addresses
// ****************************************
`define CTRL_ADDR 8'hC0
`define CONFIG_ADDR 8'hC1
`define DATA_ADDR 8'hC2

// ****************************************
// Configuration register fields
// ****************************************
`define CFG_ENABLE 7
`define CFG_INHIBIT 6
`define CFG_BUSY 5
`define CFG_STRETCH 4
`define CFG_SCL_TO 3
`define CFG_FREE_TO 2
`define CFG_RESET 8'h00

// ****************************************
// Control and status register fields
// ****************************************
`define CTL_MASTER 7
`define CTL_TXMODE 6
`define CTL_STA 5
`define CTL_STO 4
`define CTL_ACKRQ 3
`define CTL_ARBLOST 2
`define CTL_ACK 1
`define CTL_SI 0

// ****************************************
// Clock source encodings
// ****************************************
`define CS_TMR0 2'h0
`define CS_TMR1 2'h1
`define CS_TMR2H 2'h2
`define CS_TMR2L 2'h3

// ****************************************
// Timing counts in system clocks and ticks
// ****************************************
`define HOLD_NORM 5'h03
`define HOLD_EXT 5'h0C
`define SETUP_NORM 5'h01
`define SETUP_EXT 5'h0B
`define LOW_TICKS 2'h1
`define HIGH_TICKS 2'h2
`define FREE_TICKS 4'hA
`define LAST_BIT 4'h7
`define ACK_BIT 4'h8

`endif

// File: hw/byte_buffer2.v
// Two-entry buffer with valid and ready on both sides
module byte_buffer2 #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Filling side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Draining side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem_ff [0:1];
	reg wr_ptr_ff;
	reg rd_ptr_ff;
	reg [1:0] count_ff;
	wire do_push;
	wire do_pop;

	assign in_ready = (count_ff != 2'h2);
	assign out_valid = (count_ff != 2'h0);
	assign out_data = mem_ff[rd_ptr_ff];
	assign do_push = in_valid & in_ready;
	assign do_pop = out_valid & out_ready;

	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_ff[0] <= {WIDTH{1'b0}};
			mem_ff[1] <= {WIDTH{1'b0}};
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			count_ff <= 2'h0;
		end
		else
		begin
			if (do_push)
			begin
				mem_ff[wr_ptr_ff] <= in_data;
				wr_ptr_ff <= ~wr_ptr_ff;
			end
			if (do_pop)
				rd_ptr_ff <= ~rd_ptr_ff;
			if (do_push && !do_pop)
				count_ff <= count_ff + 2'h1;
			else if (do_pop && !do_push)
				count_ff <= count_ff - 2'h1;
		end
	end

endmodule // byte_buffer2

// File: hw/smbus_config_timing.v
// Two-wire bus interface: configuration, bit timing, timeouts and byte engine
`include "smbus_map.vh"

// Contract
// - Interrupt for every data byte and slave address byte on the bus.
// - When transmitting, interrupt comes after the acknowledge cycle.
// - When receiving, interrupt comes before the acknowledge cycle.
// - Interrupt after START generated as master and STOP seen as slave.
// - Enable bit 7 enables all events; pins are watched while enabled.
// - Slave inhibit bit 6 NACKs addresses, stops slave interrupts only.
// - Slave inhibit takes effect from the next START only.
// - Clock select 00/01/10/11 picks timer 0, 1, 2 high, 2 low overflow.
// - Selected source used only as master or with free timeout enabled.
// - Master clock low one overflow, high two; bit rate a third.
// - Normal hold is 3 clocks; setup is low time less 4.
// - Extended timing gives 11 clocks setup and 12 clocks hold.
// - Clock-low timeout: timer 3 reloads while clock high, else counts.
// - Split timer 3 only reloads its high byte while clock high.
// - Bus free after clock and data high over 10 source periods.
// - Busy bit 5 set during transfers, cleared by STOP or free timeout.
// - While interrupt flag set, the clock is held low; after a slave STOP or lost arbitration the flag is set with SCL released.
module smbus_config_timing (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Special-function register port
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	output wire [7:0] sfr_rdata,
	// Own slave address
	input wire [6:0] slave_addr,
	// Timer overflow pulses
	input wire tmr0_ovf,
	input wire tmr1_ovf,
	input wire tmr2h_ovf,
	input wire tmr2l_ovf,
	// Timer 3 timeout control
	input wire tmr3_split,
	output wire tmr3_reload_hi,
	output wire tmr3_reload_lo,
	// Bus clock pin
	input wire scl_in,
	output wire scl_out,
	output wire scl_oe_n,
	// Bus data pin
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe_n,
	// Interrupt
	output wire bus_irq
);

	localparam S_IDLE = 3'h0;
	localparam S_START = 3'h1;
	localparam S_XFER = 3'h2;
	localparam S_PUSH = 3'h3;
	localparam S_STALL = 3'h4;
	localparam S_STOP = 3'h5;
	localparam S_IGNORE = 3'h6;

	reg scl_m_ff, scl_s_ff, scl_d_ff;
	reg sda_m_ff, sda_s_ff, sda_d_ff;
	reg en_ff, inh_ff, busy_ff, stretch_ff, toe_ff, fte_ff;
	reg [1:0] cs_ff;
	reg master_ff, txmode_ff, sta_ff, sto_ff, ackrq_ff, arblost_ff, ack_ff;
	reg si_ff;
	reg [2:0] state_ff;
	reg [3:0] bitcnt_ff;
	reg [7:0] tx_byte_ff, tx_shift_ff, rx_shift_ff, rdata_ff;
	reg first_ff, addressed_ff, slave_on_ff, rw_ff;
	reg scl_low_ff, sda_low_ff, mhigh_ff, upd_pend_ff;
	reg [1:0] tick_cnt_ff;
	reg [4:0] low_cnt_ff, hold_cnt_ff;
	reg [3:0] free_cnt_ff;
	reg tmr3_hi_ff, tmr3_lo_ff;
	reg src_tick;
	wire tick, scl_rise, scl_fall, start_det, stop_det, free_to;
	wire [4:0] hold_min, low_min;
	wire drive_val, addr_match, accept, buf_push, buf_in_ready;
	wire buf_out_valid, buf_pop;
	wire [7:0] buf_data;

	// ****************************************
	// Pin synchronisers and bus conditions
	// ****************************************
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_m_ff <= 1'b1;
			scl_s_ff <= 1'b1;
			scl_d_ff <= 1'b1;
			sda_m_ff <= 1'b1;
			sda_s_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end
		else
		begin
			scl_m_ff <= scl_in;
			scl_s_ff <= scl_m_ff;
			scl_d_ff <= scl_s_ff;
			sda_m_ff <= sda_in;
			sda_s_ff <= sda_m_ff;
			sda_d_ff <= sda_s_ff;
		end
	end

	assign scl_rise = en_ff & scl_s_ff & ~scl_d_ff;
	assign scl_fall = en_ff & ~scl_s_ff & scl_d_ff;
	assign start_det = en_ff & scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
	assign stop_det = en_ff & scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;

	// ****************************************
	// Bit-timing tick selection
	// ****************************************
	always @*
	begin
		case (cs_ff)
			`CS_TMR0: src_tick = tmr0_ovf;
			`CS_TMR1: src_tick = tmr1_ovf;
			`CS_TMR2H: src_tick = tmr2h_ovf;
			`CS_TMR2L: src_tick = tmr2l_ovf;
			default: src_tick = 1'b0;
		endcase
	end

	// One overflow pulse is one tick; used by master or free timeout only
	assign tick = src_tick & (master_ff | fte_ff | (state_ff == S_START)
		| (state_ff == S_STOP));

	assign hold_min = stretch_ff ? `HOLD_EXT : `HOLD_NORM;
	assign low_min = stretch_ff ? (`HOLD_EXT + `SETUP_EXT)
		: (`HOLD_NORM + `SETUP_NORM);
	assign drive_val = txmode_ff & (bitcnt_ff < `ACK_BIT) & ~tx_shift_ff[7];
	assign addr_match = (rx_shift_ff[7:1] == slave_addr) & slave_on_ff;
	assign accept = master_ff | ~first_ff | addr_match;
	assign buf_push = (state_ff == S_PUSH) & accept;
	assign buf_pop = sfr_rd & (sfr_addr == `DATA_ADDR) & buf_out_valid;

	// ****************************************
	// Free timeout and busy flag
	// ****************************************
	assign free_to = fte_ff & (free_cnt_ff > `FREE_TICKS);

	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			free_cnt_ff <= 4'h0;
			busy_ff <= 1'b0;
			tmr3_hi_ff <= 1'b0;
			tmr3_lo_ff <= 1'b0;
		end
		else
		begin
			if (!(scl_s_ff & sda_s_ff) || !fte_ff || !en_ff)
				free_cnt_ff <= 4'h0;
			else if (tick && free_cnt_ff != 4'hF)
				free_cnt_ff <= free_cnt_ff + 4'h1;
			if (!en_ff)
				busy_ff <= 1'b0;
			else if (start_det)
				busy_ff <= 1'b1;
			else if (stop_det || free_to)
				busy_ff <= 1'b0;
			tmr3_hi_ff <= en_ff & toe_ff & scl_s_ff;
			tmr3_lo_ff <= en_ff & toe_ff & scl_s_ff & ~tmr3_split;
		end
	end

	// ****************************************
	// Register file and byte engine
	// ****************************************
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{en_ff, inh_ff} <= 2'h0;
			{stretch_ff, toe_ff, fte_ff} <= 3'h0;
			cs_ff <= 2'h0;
			{master_ff, txmode_ff, sta_ff, sto_ff} <= 4'h0;
			{ackrq_ff, arblost_ff, ack_ff, si_ff} <= 4'h0;
			state_ff <= S_IDLE;
			bitcnt_ff <= 4'h0;
			tx_byte_ff <= 8'h00;
			tx_shift_ff <= 8'h00;
			rx_shift_ff <= 8'h00;
			rdata_ff <= 8'h00;
			{first_ff, addressed_ff, slave_on_ff, rw_ff} <= 4'h0;
			{scl_low_ff, sda_low_ff, mhigh_ff, upd_pend_ff} <= 4'h0;
			tick_cnt_ff <= 2'h0;
			low_cnt_ff <= 5'h00;
			hold_cnt_ff <= 5'h00;
		end
		else
		begin
			if (sfr_rd)
			begin
				case (sfr_addr)
					`CONFIG_ADDR: rdata_ff <= {en_ff, inh_ff, busy_ff,
						stretch_ff, toe_ff, fte_ff, cs_ff};
					`CTRL_ADDR: rdata_ff <= {master_ff, txmode_ff, sta_ff,
						sto_ff, ackrq_ff, arblost_ff, ack_ff, si_ff};
					`DATA_ADDR: rdata_ff <= buf_out_valid ? buf_data
						: rx_shift_ff;
					default: rdata_ff <= 8'h00;
				endcase
			end
			if (sfr_wr && sfr_addr == `CONFIG_ADDR)
			begin
				en_ff <= sfr_wdata[`CFG_ENABLE];
				inh_ff <= sfr_wdata[`CFG_INHIBIT];
				stretch_ff <= sfr_wdata[`CFG_STRETCH];
				toe_ff <= sfr_wdata[`CFG_SCL_TO];
				fte_ff <= sfr_wdata[`CFG_FREE_TO];
				cs_ff <= sfr_wdata[1:0];
			end
			if (sfr_wr && sfr_addr == `CTRL_ADDR)
			begin
				sta_ff <= sfr_wdata[`CTL_STA];
				sto_ff <= sfr_wdata[`CTL_STO];
				ack_ff <= sfr_wdata[`CTL_ACK];
				si_ff <= sfr_wdata[`CTL_SI];
				if (!sfr_wdata[`CTL_SI])
					arblost_ff <= 1'b0;
			end
			if (sfr_wr && sfr_addr == `DATA_ADDR)
				tx_byte_ff <= sfr_wdata;
			// Data changes only after the hold delay past a falling edge
			if (upd_pend_ff)
			begin
				if (hold_cnt_ff == 5'h00)
				begin
					sda_low_ff <= drive_val;
					upd_pend_ff <= 1'b0;
				end
				else
					hold_cnt_ff <= hold_cnt_ff - 5'h01;
			end
			if (!en_ff)
			begin
				state_ff <= S_IDLE;
				{master_ff, txmode_ff, addressed_ff} <= 3'h0;
				{scl_low_ff, sda_low_ff, upd_pend_ff} <= 3'h0;
			end
			else
			begin
				case (state_ff)
					S_IDLE:
					begin
						scl_low_ff <= 1'b0;
						sda_low_ff <= 1'b0;
						tick_cnt_ff <= 2'h0;
						if (sta_ff && !busy_ff && !si_ff)
							state_ff <= S_START;
					end
					S_START:
					begin
						sda_low_ff <= 1'b1;
						if (tick && tick_cnt_ff == `LOW_TICKS)
						begin
							scl_low_ff <= 1'b1;
							{master_ff, txmode_ff, first_ff} <= 3'h7;
							bitcnt_ff <= 4'h0;
							si_ff <= 1'b1;
							state_ff <= S_STALL;
						end
						else if (tick)
							tick_cnt_ff <= tick_cnt_ff + 2'h1;
					end
					S_STALL:
					begin
						scl_low_ff <= 1'b1;
						if (!txmode_ff && bitcnt_ff == `ACK_BIT)
							sda_low_ff <= ack_ff;
						if (!si_ff)
						begin
							{mhigh_ff, tick_cnt_ff, low_cnt_ff} <= 8'h00;
							if (bitcnt_ff == `ACK_BIT)
								state_ff <= S_XFER;
							else if (master_ff && sto_ff)
								state_ff <= S_STOP;
							else
							begin
								if (txmode_ff)
									tx_shift_ff <= tx_byte_ff;
								if (first_ff)
									rw_ff <= tx_byte_ff[0];
								hold_cnt_ff <= hold_min;
								upd_pend_ff <= 1'b1;
								state_ff <= S_XFER;
							end
						end
					end
					S_PUSH:
					begin
						scl_low_ff <= 1'b1;
						if (!accept)
						begin
							scl_low_ff <= 1'b0;
							state_ff <= S_IGNORE;
						end
						else if (buf_in_ready)
						begin
							if (first_ff && !master_ff)
							begin
								addressed_ff <= 1'b1;
								sta_ff <= 1'b1;
								rw_ff <= rx_shift_ff[0];
							end
							ackrq_ff <= 1'b1;
							si_ff <= 1'b1;
							state_ff <= S_STALL;
						end
					end
					S_XFER:
					begin
						if (!master_ff)
							scl_low_ff <= 1'b0;
						else if (!mhigh_ff)
						begin
							scl_low_ff <= 1'b1;
							if (low_cnt_ff != 5'h1F)
								low_cnt_ff <= low_cnt_ff + 5'h01;
							if (tick && tick_cnt_ff != 2'h3)
								tick_cnt_ff <= tick_cnt_ff + 2'h1;
							if (tick_cnt_ff >= `LOW_TICKS && !upd_pend_ff
								&& low_cnt_ff >= low_min)
							begin
								scl_low_ff <= 1'b0;
								mhigh_ff <= 1'b1;
								tick_cnt_ff <= 2'h0;
							end
						end
						else if (scl_s_ff && tick)
						begin
							if ((tick_cnt_ff + 2'h1) == `HIGH_TICKS)
							begin
								scl_low_ff <= 1'b1;
								{mhigh_ff, tick_cnt_ff, low_cnt_ff} <= 8'h00;
							end
							else
								tick_cnt_ff <= tick_cnt_ff + 2'h1;
						end
						if (scl_rise && bitcnt_ff < `ACK_BIT)
						begin
							rx_shift_ff <= {rx_shift_ff[6:0], sda_s_ff};
							if (txmode_ff && tx_shift_ff[7] && !sda_s_ff)
							begin
								arblost_ff <= 1'b1;
								si_ff <= 1'b1;
								{master_ff, txmode_ff} <= 2'h0;
								{scl_low_ff, sda_low_ff} <= 2'h0;
								state_ff <= S_IGNORE;
							end
						end
						else if (scl_rise && txmode_ff)
							ack_ff <= ~sda_s_ff;
						if (scl_fall && bitcnt_ff < `LAST_BIT)
						begin
							bitcnt_ff <= bitcnt_ff + 4'h1;
							tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
							hold_cnt_ff <= hold_min;
							upd_pend_ff <= 1'b1;
						end
						else if (scl_fall && bitcnt_ff == `LAST_BIT)
						begin
							bitcnt_ff <= `ACK_BIT;
							tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
							if (txmode_ff)
							begin
								hold_cnt_ff <= hold_min;
								upd_pend_ff <= 1'b1;
							end
							else
							begin
								scl_low_ff <= 1'b1;
								state_ff <= S_PUSH;
							end
						end
						else if (scl_fall)
						begin
							bitcnt_ff <= 4'h0;
							ackrq_ff <= 1'b0;
							first_ff <= 1'b0;
							hold_cnt_ff <= hold_min;
							upd_pend_ff <= 1'b1;
							if (txmode_ff)
							begin
								if (first_ff)
									txmode_ff <= ~rw_ff;
								scl_low_ff <= 1'b1;
								si_ff <= 1'b1;
								state_ff <= S_STALL;
							end
							else if (master_ff && sto_ff)
								state_ff <= S_STOP;
							else if (first_ff && !master_ff && rw_ff)
							begin
								txmode_ff <= 1'b1;
								tx_shift_ff <= tx_byte_ff;
							end
						end
					end
					S_STOP:
					begin
						if (!mhigh_ff)
						begin
							scl_low_ff <= 1'b1;
							sda_low_ff <= 1'b1;
							if (low_cnt_ff != 5'h1F)
								low_cnt_ff <= low_cnt_ff + 5'h01;
							if (tick && low_cnt_ff >= hold_min)
							begin
								scl_low_ff <= 1'b0;
								mhigh_ff <= 1'b1;
							end
						end
						else if (scl_s_ff && tick)
						begin
							sda_low_ff <= 1'b0;
							{master_ff, txmode_ff, sto_ff} <= 3'h0;
							state_ff <= S_IDLE;
						end
					end
					S_IGNORE:
					begin
						scl_low_ff <= 1'b0;
						sda_low_ff <= 1'b0;
					end
					default:
						state_ff <= S_IDLE;
				endcase
				if (start_det)
				begin
					slave_on_ff <= ~inh_ff;
					first_ff <= 1'b1;
					addressed_ff <= 1'b0;
					if (state_ff != S_START)
					begin
						{master_ff, txmode_ff} <= 2'h0;
						bitcnt_ff <= 4'h0;
						{scl_low_ff, sda_low_ff, upd_pend_ff} <= 3'h0;
						state_ff <= S_XFER;
					end
				end
				if (stop_det && state_ff != S_STOP)
				begin
					if (addressed_ff && slave_on_ff)
					begin
						si_ff <= 1'b1;
						sto_ff <= 1'b1;
					end
					addressed_ff <= 1'b0;
					{scl_low_ff, sda_low_ff, upd_pend_ff} <= 3'h0;
					state_ff <= S_IDLE;
				end
			end
		end
	end

	// ****************************************
	// Received-byte buffer and outputs
	// ****************************************
	byte_buffer2 #(
		.WIDTH(8)
	) u_rx_buf (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.in_valid(buf_push),
		.in_ready(buf_in_ready),
		.in_data(rx_shift_ff),
		.out_valid(buf_out_valid),
		.out_ready(buf_pop),
		.out_data(buf_data)
	);

	assign sfr_rdata = rdata_ff;
	assign scl_out = 1'b0;
	assign scl_oe_n = ~scl_low_ff;
	assign sda_out = 1'b0;
	assign sda_oe_n = ~sda_low_ff;
	assign tmr3_reload_hi = tmr3_hi_ff;
	assign tmr3_reload_lo = tmr3_lo_ff;
	assign bus_irq = si_ff;

endmodule // smbus_config_timing

// File: testbench/smbus_config_timing_asserts.sv
// Concurrent checks on the ports of the two-wire bus block
module smbus_config_timing_asserts (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Register port
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata,
	input wire [6:0] slave_addr,
	// Timers
	input wire tmr0_ovf,
	input wire tmr1_ovf,
	input wire tmr2h_ovf,
	input wire tmr2l_ovf,
	input wire tmr3_split,
	input wire tmr3_reload_hi,
	input wire tmr3_reload_lo,
	// Bus pins and interrupt
	input wire scl_in,
	input wire scl_out,
	input wire scl_oe_n,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe_n,
	input wire bus_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cfg_ff;
	logic [1:0] lo_ff;
	logic [1:0] hi_ff;
	wire tick = cfg_ff[1] ? (cfg_ff[0] ? tmr2l_ovf : tmr2h_ovf)
		: (cfg_ff[0] ? tmr1_ovf : tmr0_ovf);
	wire toe_on = cfg_ff[7] & cfg_ff[3];
	// Config shadow and ticks seen per driven SCL phase, saturating at 2
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_ff <= 8'h00;
			lo_ff <= 2'h0;
			hi_ff <= 2'h0;
		end
		else
		begin
			if (sfr_wr && sfr_addr == 8'hC1)
				cfg_ff <= sfr_wdata;
			lo_ff <= scl_oe_n ? 2'h0 : lo_ff + {1'b0, tick & ~lo_ff[1]};
			hi_ff <= !scl_oe_n ? 2'h0 : hi_ff + {1'b0, tick & ~hi_ff[1]};
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	hold_norm_a: assert property (
		$fell(scl_in) && !cfg_ff[4] |-> $stable(sda_oe_n)[*3])
		else $error("data hold short");
	hold_ext_a: assert property (
		$fell(scl_in) && cfg_ff[4]
		|-> $stable(sda_oe_n)[*8] ##1 $stable(sda_oe_n)[*4])
		else $error("extended data hold short");
	reload_high_a: assert property (
		(toe_on && scl_in)[*5] |-> tmr3_reload_hi)
		else $error("timer 3 not held while SCL high");
	count_low_a: assert property (
		(!scl_in)[*5] |-> !tmr3_reload_hi && !tmr3_reload_lo)
		else $error("timer 3 held while SCL low");
	split_hi_only_a: assert property (
		(toe_on && scl_in && tmr3_split)[*5] |-> !tmr3_reload_lo)
		else $error("split low byte held");
	reload_low_a: assert property (
		(toe_on && scl_in && !tmr3_split)[*5] |-> tmr3_reload_lo)
		else $error("low byte not held");
	irq_stall_a: assert property (
		bus_irq[*3] |-> !scl_oe_n)
		else $error("SCL released while flag set");
	irq_scl_low_a: assert property (
		$rose(bus_irq) |-> ##[0:4] !scl_in)
		else $error("flag set with SCL high");
	cfg_read_a: assert property (
		sfr_rd && sfr_addr == 8'hC1
		|=> (sfr_rdata & 8'hDF) == ($past(cfg_ff) & 8'hDF))
		else $error("config readback wrong");
	busy_mid_a: assert property (
		sfr_rd && sfr_addr == 8'hC1 && !scl_in |=> sfr_rdata[5])
		else $error("busy clear mid transfer");
	low_tick_a: assert property (
		$rose(scl_oe_n) |-> lo_ff != 2'h0)
		else $error("SCL low under one tick");
	high_tick_a: assert property (
		$fell(scl_oe_n) |-> hi_ff == 2'h2)
		else $error("SCL high under two ticks");
endmodule // smbus_config_timing_asserts

bind smbus_config_timing smbus_config_timing_asserts chk_u (
	.sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
	.sfr_rdata(sfr_rdata), .slave_addr(slave_addr),
	.tmr0_ovf(tmr0_ovf), .tmr1_ovf(tmr1_ovf), .tmr2h_ovf(tmr2h_ovf),
	.tmr2l_ovf(tmr2l_ovf), .tmr3_split(tmr3_split),
	.tmr3_reload_hi(tmr3_reload_hi), .tmr3_reload_lo(tmr3_reload_lo),
	.scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
	.bus_irq(bus_irq));

// File: testbench/bus_peer_model.sv
// Behavioural bus peer: a slave that takes writes and answers reads
module bus_peer_model #(
	parameter logic [6:0] ADDR = 7'h5A,
	parameter logic [7:0] TX = 8'hA5
) (
	// Bus wires
	input wire scl,
	input wire sda,
	// Clock stretch request
	input wire slow,
	// Open-drain pulls, high while pulling low
	output logic scl_low,
	output logic sda_low,
	// Last byte seen on the bus
	output logic [7:0] last_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh = 8'h00;
	int bitn = -1;
	int cnt = 0;
	logic sel = 1'b0;
	logic rdm = 1'b0;
	initial
	begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		last_byte = 8'h00;
	end
	// START arms the bit counter, STOP idles it
	always @(negedge sda)
		if (scl)
		begin
			bitn = 0;
			cnt = 0;
			sel = 1'b0;
		end
	always @(posedge sda)
		if (scl)
			bitn = -1;
	// Sample MSB first while SCL high; a read NACK ends the slave's turn
	always @(posedge scl)
		if (bitn >= 0 && bitn < 8)
		begin
			sh = {sh[6:0], sda};
			bitn++;
		end
		else if (bitn == 9 && rdm && sda)
			sel = 1'b0;
	// Launch acknowledge and read data only while SCL is low
	always @(negedge scl)
	begin
		if (bitn == 8)
		begin
			if (cnt == 0)
			begin
				sel = (sh[7:1] == ADDR);
				rdm = sh[0];
			end
			cnt++;
			last_byte = sh;
			sda_low = sel && !(rdm && cnt > 1);
			bitn = 9;
		end
		else if (bitn == 9)
			bitn = 0;
		if (bitn >= 0 && bitn < 8)
			sda_low = sel && rdm && !TX[7 - bitn];
		if (slow)
		begin
			scl_low = 1'b1;
			scl_low <= #300 1'b0;
		end
	end
endmodule // bus_peer_model

// File: testbench/testbench.sv
// Self-checking bench for the two-wire bus block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] PEER = 7'h5A;
	localparam logic [7:0] RD_BYTE = 8'h3C;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [3:0] ovf = 4'h0;
	logic tmr3_split = 1'b0;
	logic slow = 1'b0;
	logic [1:0] src = 2'h0;
	logic [4:0] tcnt = 5'h00;
	logic [7:0] v;
	int err_count = 0;
	int total_checks = 0;
	wire [7:0] sfr_rdata;
	wire [7:0] peer_byte;
	wire scl_oe_n, scl_out, sda_oe_n, sda_out, bus_irq, peer_scl, peer_sda;
	// Pulled-up open-drain wires
	wire scl = (scl_oe_n | scl_out) & !peer_scl;
	wire sda = (sda_oe_n | sda_out) & !peer_sda;
	always #5 sys_clk = ~sys_clk;
	// Selected timer overflows every 25 clocks, never stopped
	always @(posedge sys_clk)
	begin
		tcnt <= (tcnt == 5'h18) ? 5'h00 : tcnt + 5'h01;
		ovf <= (tcnt == 5'h00) ? 4'h1 << src : 4'h0;
	end
	smbus_config_timing dut_u (
		.sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .slave_addr(7'h21),
		.tmr0_ovf(ovf[0]), .tmr1_ovf(ovf[1]), .tmr2h_ovf(ovf[2]),
		.tmr2l_ovf(ovf[3]), .tmr3_split(tmr3_split),
		.tmr3_reload_hi(), .tmr3_reload_lo(), .scl_in(scl),
		.scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .bus_irq(bus_irq));
	bus_peer_model #(.ADDR(PEER), .TX(RD_BYTE)) peer_u (
		.scl(scl), .sda(sda), .slow(slow), .scl_low(peer_scl),
		.sda_low(peer_sda), .last_byte(peer_byte));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge sys_clk);
		sfr_wr <= 1'b0;
	endtask
	// Mask of zero reads without comparing
	task automatic rd(input logic [7:0] a, m, e);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge sys_clk);
		sfr_rd <= 1'b0;
		#1 v = sfr_rdata;
		if (m != 8'h00)
			chk(v & m, e);
	endtask
	task automatic wait_irq();
		repeat (4000)
		begin
			@(posedge sys_clk);
			#1;
			if (bus_irq === 1'b1)
				break;
		end
		chk({7'h00, bus_irq}, 8'h01);
	endtask
	// Master transfer: address byte, then one byte in the direction of its R/W bit if acked
	task automatic xfer(input logic [1:0] cs, input logic [7:0] cfg, ab, d);
		logic ack;
		ack = (ab[7:1] == PEER);
		wr(8'hC1, cfg | {6'h00, cs});
		src <= cs;
		wr(8'hC2, ab);
		wr(8'hC0, 8'h20);
		wait_irq();
		rd(8'hC0, 8'hF1, 8'hE1);
		rd(8'hC1, 8'hFF, cfg | {6'h00, cs} | 8'h20);
		wr(8'hC0, 8'h00);
		wait_irq();
		rd(8'hC0, 8'hCB, {1'b1, ~ab[0], 4'h0, ack, 1'b1});
		if (ack && !ab[0])
		begin
			wr(8'hC2, d);
			wr(8'hC0, 8'h00);
			wait_irq();
			rd(8'hC0, 8'hCB, 8'hC3);
			chk(peer_byte, d);
		end
		if (ack && ab[0])
		begin
			wr(8'hC0, 8'h00);
			wait_irq();
			rd(8'hC0, 8'hC9, 8'h89);
			rd(8'hC2, 8'hFF, d);
		end
		wr(8'hC0, 8'h10);
		repeat (100)
		begin
			rd(8'hC1, 8'h00, 8'h00);
			if (v[5] === 1'b0)
				break;
		end
		rd(8'hC1, 8'hA0, 8'h80);
	endtask
	task automatic complete_run();
		if (err_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(8'hC1, 8'hFF, 8'h00);
		rd(8'hC0, 8'hFF, 8'h00);
		wr(8'hC1, 8'h7F);
		rd(8'hC1, 8'hFF, 8'h5F);
		rd(8'hC3, 8'hFF, 8'h00);
		wr(8'hC1, 8'h00);
		xfer(2'h0, 8'h80, {PEER, 1'b0}, 8'h96);
		slow <= 1'b1;
		tmr3_split <= 1'b1;
		xfer(2'h1, 8'h98, {PEER, 1'b0}, 8'h69);
		slow <= 1'b0;
		tmr3_split <= 1'b0;
		xfer(2'h2, 8'h88, 8'h42, 8'h00);
		xfer(2'h3, 8'h84, {PEER, 1'b1}, RD_BYTE);
		// Timeout recovery: disable, then re-enable the interface
		wr(8'hC1, 8'h00);
		wr(8'hC1, 8'h88);
		rd(8'hC1, 8'hFF, 8'h88);
		complete_run();
	end
	initial
	begin
		#500us;
		err_count++;
		complete_run();
	end
endmodule // testbench
